// File: hdl/pssp_fifo.sv
// shared constants and the write-data buffer of the sram port
`timescale 1ns/1ps
`default_nettype none

package pssp_pkg;
  localparam int          PSSP_LANES       = 4;
  localparam int          PSSP_LANE_W      = 8;
  localparam int          PSSP_DATA_W      = PSSP_LANES * PSSP_LANE_W;
  localparam int          PSSP_WORD_W      = PSSP_DATA_W + PSSP_LANES;
  localparam int          PSSP_ADDR_W      = 6;
  localparam int          PSSP_BURST_W     = 2;
  localparam int          PSSP_FIFO_DEPTH  = 4;
  localparam int          PSSP_ENTRY_W     = PSSP_ADDR_W + PSSP_LANES + PSSP_WORD_W;
  localparam logic        PSSP_ORDER_LINEAR = 1'b0;
  localparam logic [1:0]  PSSP_SYNC_RST    = 2'h0;
  localparam logic        PSSP_STRAP_RST   = 1'b1;
  localparam logic        PSSP_OE_N_RST    = 1'b1;
  typedef enum logic [1:0] {PSSP_OP_IDLE, PSSP_OP_READ, PSSP_OP_WRITE} pssp_op_t;
endpackage : pssp_pkg

module pssp_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic           i_clk,
  input  wire logic           i_rst_n,
  input  wire logic           i_in_valid,
  input  wire logic [W-1:0]   i_in_data,
  output logic                o_in_ready,
  output logic                o_out_valid,
  output logic [W-1:0]        o_out_data,
  input  wire logic           i_out_ready,
  output logic [D*W-1:0]      o_peek,
  output logic [D-1:0]        o_peek_valid
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem_reg [D];
  logic [W-1:0]  mem_next [D];
  logic [PW-1:0] rd_ptr_reg, rd_ptr_next, wr_ptr_reg, wr_ptr_next;
  logic [CW-1:0] count_reg, count_next;
  logic          push, pop;

  assign o_in_ready  = (count_reg < CW'(D));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data  = mem_reg[rd_ptr_reg];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always_comb begin
    int idx;
    idx = 0;
    mem_next    = mem_reg;
    rd_ptr_next = rd_ptr_reg;
    wr_ptr_next = wr_ptr_reg;
    count_next  = count_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = i_in_data;
      wr_ptr_next = (wr_ptr_reg == PW'(D - 1)) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = (rd_ptr_reg == PW'(D - 1)) ? '0 : rd_ptr_reg + 1'b1;
    end
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
    // peek entries oldest first, so a later entry overrides an earlier one
    for (int i = 0; i < D; i++) begin
      idx = (int'(rd_ptr_reg) + i) % D;
      o_peek[i*W +: W] = mem_reg[idx];
      o_peek_valid[i]  = (i < int'(count_reg));
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < D; i++) begin
        mem_reg[i] <= '0;
      end
      rd_ptr_reg <= '0;
      wr_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      mem_reg    <= mem_next;
      rd_ptr_reg <= rd_ptr_next;
      wr_ptr_reg <= wr_ptr_next;
      count_reg  <= count_next;
    end
  end
endmodule : pssp_fifo

`default_nettype wire

// File: hdl/pssp_port.sv
// pin-level control of a pipelined synchronous burst sram with byte lanes
`timescale 1ns/1ps
`default_nettype none

module pssp_port
  import pssp_pkg::*;
#(
  parameter int ADDR_W = PSSP_ADDR_W,
  parameter int DEPTH  = PSSP_FIFO_DEPTH
) (
  input  wire logic                  I_REF_CLK,
  input  wire logic                  I_RST_N,
  input  wire logic                  I_CLOCK_HOLD_N,
  input  wire logic                  I_SELECT_LOW_FIRST_N,
  input  wire logic                  I_SELECT_HIGH_SECOND,
  input  wire logic                  I_SELECT_LOW_THIRD_N,
  input  wire logic                  I_ADVANCE_OR_LOAD_N,
  input  wire logic                  I_WRITE_SELECT_N,
  input  wire logic [PSSP_LANES-1:0] I_LANE_WRITE_SELECT_N,
  input  wire logic [ADDR_W-1:0]     I_ADDR,
  input  wire logic                  I_OUTPUT_ENABLE_N,
  input  wire logic [PSSP_DATA_W-1:0] I_DATA_LANES,
  output logic [PSSP_DATA_W-1:0]     O_DATA_LANES,
  output logic                       O_DATA_LANES_OE_N,
  input  wire logic [PSSP_LANES-1:0] I_PARITY_LANES,
  output logic [PSSP_LANES-1:0]      O_PARITY_LANES,
  output logic                       O_PARITY_LANES_OE_N,
  input  wire logic                  I_BURST_ORDER,
  input  wire logic                  I_TEST_CLK,
  input  wire logic                  I_TEST_DATA_IN,
  output logic                       O_TEST_DATA_OUT,
  output logic                       O_WBUF_READY
);
  localparam int EW = ADDR_W + PSSP_LANES + PSSP_WORD_W;

  // pin synchronisers: oe, strap, test clock, test data
  logic [3:0] sync1_reg, sync2_reg;
  logic       tck_prev_reg;
  logic       oe_n_s, strap_s, tck_s, tdi_s;

  // command stage
  pssp_op_t                      op_reg, op_next;
  logic [ADDR_W-1:0]             base_reg, base_next;
  logic [PSSP_BURST_W-1:0]       cnt_reg, cnt_next;
  logic [PSSP_LANES-1:0]         mask_reg, mask_next;
  // read output stage
  logic [PSSP_WORD_W-1:0]        rd_reg, rd_next;
  logic                          out_active_reg, out_active_next;
  // array and test port
  logic [PSSP_WORD_W-1:0]        mem_reg [2**ADDR_W];
  logic [PSSP_WORD_W-1:0]        mem_next [2**ADDR_W];
  logic                          bypass_reg, bypass_next;
  logic                          tdo_reg, tdo_next;

  logic                          en, selected, drive;
  logic [PSSP_BURST_W-1:0]       low_addr;
  logic [ADDR_W-1:0]             addr_cur;
  logic                          push_valid, push_ready;
  logic [EW-1:0]                 push_data;
  logic                          pop_valid, pop_ready;
  logic [EW-1:0]                 pop_data;
  logic [DEPTH*EW-1:0]           peek;
  logic [DEPTH-1:0]              peek_valid;

  assign oe_n_s  = sync2_reg[0];
  assign strap_s = sync2_reg[1];
  assign tck_s   = sync2_reg[2];
  assign tdi_s   = sync2_reg[3];

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sync1_reg    <= {PSSP_SYNC_RST, PSSP_STRAP_RST, PSSP_OE_N_RST};
      sync2_reg    <= {PSSP_SYNC_RST, PSSP_STRAP_RST, PSSP_OE_N_RST};
      tck_prev_reg <= 1'b0;
    end else begin
      sync1_reg    <= {I_TEST_DATA_IN, I_TEST_CLK, I_BURST_ORDER, I_OUTPUT_ENABLE_N};
      sync2_reg    <= sync1_reg;
      tck_prev_reg <= tck_s;
    end
  end

  // edge qualified by hold; a full buffer also holds so no write is lost
  assign en = ~I_CLOCK_HOLD_N & push_ready;
  assign O_WBUF_READY = push_ready;
  assign selected = ~I_SELECT_LOW_FIRST_N & I_SELECT_HIGH_SECOND & ~I_SELECT_LOW_THIRD_N;

  // only the two low bits step and wrap
  // strap chooses xor (interleaved) or add (linear)
  assign low_addr = (strap_s == PSSP_ORDER_LINEAR) ?
                    base_reg[PSSP_BURST_W-1:0] + cnt_reg :
                    base_reg[PSSP_BURST_W-1:0] ^ cnt_reg;
  assign addr_cur = {base_reg[ADDR_W-1:PSSP_BURST_W], low_addr};

  // lanes and parity sampled together in the write data cycle
  assign push_valid = en & (op_reg == PSSP_OP_WRITE);
  assign push_data  = {addr_cur, mask_reg, I_PARITY_LANES, I_DATA_LANES};
  // the single array port serves a read first; drain waits a cycle
  assign pop_ready  = ~I_CLOCK_HOLD_N & ~(en & (op_reg == PSSP_OP_READ));

  pssp_fifo #(
    .W (EW),
    .D (DEPTH)
  ) u_wbuf (
    .i_clk        (I_REF_CLK),
    .i_rst_n      (I_RST_N),
    .i_in_valid   (push_valid),
    .i_in_data    (push_data),
    .o_in_ready   (push_ready),
    .o_out_valid  (pop_valid),
    .o_out_data   (pop_data),
    .i_out_ready  (pop_ready),
    .o_peek       (peek),
    .o_peek_valid (peek_valid)
  );

  always_comb begin
    logic [PSSP_WORD_W-1:0] word;
    logic [EW-1:0]          ent;
    logic [ADDR_W-1:0]      waddr;
    word            = mem_reg[addr_cur];
    ent             = '0;
    waddr           = pop_data[EW-1 -: ADDR_W];
    op_next         = op_reg;
    base_next       = base_reg;
    cnt_next        = cnt_reg;
    mask_next       = mask_reg;
    rd_next         = rd_reg;
    out_active_next = out_active_reg;
    mem_next        = mem_reg;
    bypass_next     = bypass_reg;
    tdo_next        = tdo_reg;
    // nothing but the test port moves while held, and the stage is kept, not dropped
    if (en) begin
      if (I_ADVANCE_OR_LOAD_N) begin
        // advance keeps access type, fresh byte selects per beat
        cnt_next  = cnt_reg + 1'b1;
        mask_next = ~I_LANE_WRITE_SELECT_N;
      end else if (selected) begin
        op_next   = I_WRITE_SELECT_N ? PSSP_OP_READ : PSSP_OP_WRITE;
        base_next = I_ADDR;
        cnt_next  = '0;
        mask_next = ~I_LANE_WRITE_SELECT_N;
      end else begin
        op_next = PSSP_OP_IDLE;
      end
      // data for the address of the previous edge, merged with pending writes
      if (op_reg == PSSP_OP_READ) begin
        for (int i = 0; i < DEPTH; i++) begin
          ent = peek[i*EW +: EW];
          if (peek_valid[i] && ent[EW-1 -: ADDR_W] == addr_cur) begin
            for (int l = 0; l < PSSP_LANES; l++) begin
              if (ent[PSSP_WORD_W + l]) begin
                word[l*PSSP_LANE_W +: PSSP_LANE_W] = ent[l*PSSP_LANE_W +: PSSP_LANE_W];
                word[PSSP_DATA_W + l] = ent[PSSP_DATA_W + l];
              end
            end
          end
        end
        rd_next = word;
      end
      out_active_next = (op_reg == PSSP_OP_READ);
    end
    // each lane and its parity bit under its own select
    if (pop_valid && pop_ready) begin
      for (int l = 0; l < PSSP_LANES; l++) begin
        if (pop_data[PSSP_WORD_W + l]) begin
          mem_next[waddr][l*PSSP_LANE_W +: PSSP_LANE_W] = pop_data[l*PSSP_LANE_W +: PSSP_LANE_W];
          mem_next[waddr][PSSP_DATA_W + l] = pop_data[PSSP_DATA_W + l];
        end
      end
    end
    if (tck_s && !tck_prev_reg) begin
      bypass_next = tdi_s;
    end
    if (!tck_s && tck_prev_reg) begin
      tdo_next = bypass_reg;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      op_reg         <= PSSP_OP_IDLE;
      base_reg       <= '0;
      cnt_reg        <= '0;
      mask_reg       <= '0;
      rd_reg         <= '0;
      out_active_reg <= 1'b0;
      for (int i = 0; i < 2**ADDR_W; i++) begin
        mem_reg[i] <= '0;
      end
      bypass_reg     <= 1'b0;
      tdo_reg        <= 1'b0;
    end else begin
      op_reg         <= op_next;
      base_reg       <= base_next;
      cnt_reg        <= cnt_next;
      mask_reg       <= mask_next;
      rd_reg         <= rd_next;
      out_active_reg <= out_active_next;
      mem_reg        <= mem_next;
      bypass_reg     <= bypass_next;
      tdo_reg        <= tdo_next;
    end
  end

  // forced off in the write data cycle; after deselect no read is in flight
  assign drive = out_active_reg & (op_reg != PSSP_OP_WRITE) & ~oe_n_s;
  assign O_DATA_LANES_OE_N   = ~drive;
  assign O_PARITY_LANES_OE_N = ~drive;
  assign O_DATA_LANES        = rd_reg[PSSP_DATA_W-1:0];
  assign O_PARITY_LANES      = rd_reg[PSSP_WORD_W-1:PSSP_DATA_W];
  assign O_TEST_DATA_OUT     = tdo_reg;
endmodule : pssp_port

`default_nettype wire

// File: sim/pssp_host.sv
// host controller model driving the sram command pins
`timescale 1ns/1ps
`default_nettype none
module pssp_host (
  input  wire logic        i_clk,
  input  wire logic        i_rdy,
  input  wire logic        i_oe_n,
  input  wire logic [35:0] i_q,
  output logic             o_hold_n,
  output logic [2:0]       o_sel,
  output logic             o_adv_n,
  output logic             o_we_n,
  output logic [3:0]       o_bw_n,
  output logic [5:0]       o_addr,
  output logic [35:0]      o_d
);
  logic [35:0] wd = 36'h0;
  logic [35:0] pd = 36'h0;
  logic        drv = 1'b0;
  logic        pw = 1'b0;
  // select levels used when not selecting; a scenario may pick a partial miss
  logic [2:0]  desel = 3'b101;
  int          hung = 0;
  initial {o_hold_n, o_sel, o_adv_n, o_we_n, o_bw_n, o_addr} = 16'h57c0;
  // released lanes show the inverse so stale data never looks valid
  assign o_d = !i_oe_n ? i_q : (drv ? wd : ~wd);
  // one command, held until an unheld ready edge takes it
  task automatic op(input logic s, input logic w, input logic [3:0] b,
                    input logic [5:0] a, input logic [35:0] dat);
    int n;
    logic taken;
    // write needs load and all selects
    o_sel <= s ? 3'b010 : desel;
    o_adv_n <= 1'b0;
    o_we_n <= !w;
    o_bw_n <= b;
    o_addr <= a;
    wd <= pd;
    drv <= pw;
    pd = dat;
    pw = s && w;
    n = 0;
    taken = 1'b0;
    do begin
      @(posedge i_clk);
      n++;
      taken = !o_hold_n && i_rdy;
    end while (!taken && n < 50);
    if (!taken) hung++;
  endtask : op
endmodule : pssp_host
`default_nettype wire

// File: sim/pssp_port_chk.sv
// pin-level assertions for the sram port
`timescale 1ns/1ps
`default_nettype none
module pssp_port_chk
  import pssp_pkg::*;
(
  input wire logic                   I_REF_CLK,
  input wire logic                   I_RST_N,
  input wire logic                   I_CLOCK_HOLD_N,
  input wire logic                   I_SELECT_LOW_FIRST_N,
  input wire logic                   I_SELECT_HIGH_SECOND,
  input wire logic                   I_SELECT_LOW_THIRD_N,
  input wire logic                   I_ADVANCE_OR_LOAD_N,
  input wire logic                   I_WRITE_SELECT_N,
  input wire logic                   I_OUTPUT_ENABLE_N,
  input wire logic [PSSP_DATA_W-1:0] O_DATA_LANES,
  input wire logic                   O_DATA_LANES_OE_N,
  input wire logic [PSSP_LANES-1:0]  O_PARITY_LANES,
  input wire logic                   O_PARITY_LANES_OE_N,
  input wire logic                   I_TEST_CLK,
  input wire logic                   O_TEST_DATA_OUT,
  input wire logic                   O_WBUF_READY
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);
  wire en  = !I_CLOCK_HOLD_N && O_WBUF_READY;
  wire sel = !I_SELECT_LOW_FIRST_N && I_SELECT_HIGH_SECOND && !I_SELECT_LOW_THIRD_N;
  wire ld  = !I_ADVANCE_OR_LOAD_N;
  // pin histories cover the output enable and test clock sync lag
  logic [3:0] oeh;
  logic [7:0] tch;
  always_ff @(posedge I_REF_CLK) begin
    oeh <= {oeh[2:0], I_OUTPUT_ENABLE_N};
    tch <= {tch[6:0], I_TEST_CLK};
  end
  a_hold_freeze: assert property (I_CLOCK_HOLD_N |=> $stable(O_DATA_LANES))
    else $error("data changed on held edge");
  a_hold_parity_freeze: assert property (I_CLOCK_HOLD_N |=> $stable(O_PARITY_LANES))
    else $error("parity changed on held edge");
  a_hold_keeps: assert property (I_CLOCK_HOLD_N && oeh == 4'h0 |=> $stable(O_DATA_LANES_OE_N))
    else $error("hold changed drive state");
  a_oe_high_off: assert property (&oeh |-> O_DATA_LANES_OE_N)
    else $error("lanes driven with enable high");
  a_parity_oe_same: assert property (O_PARITY_LANES_OE_N == O_DATA_LANES_OE_N)
    else $error("parity enable differs");
  a_write_lanes_off: assert property (en && sel && ld && !I_WRITE_SELECT_N |=> O_DATA_LANES_OE_N)
    else $error("lanes driven in write");
  a_desel_lanes_off: assert property (en && !sel && ld ##1 en |=> O_DATA_LANES_OE_N)
    else $error("lanes driven after deselect");
  a_adv_stays_idle: assert property (en && !sel && ld ##1 en && !ld ##1 en |=> O_DATA_LANES_OE_N)
    else $error("advance left idle");
  // a write loaded right behind the read takes the lanes for its data
  a_read_drives: assert property (en && sel && ld && I_WRITE_SELECT_N
    ##1 en && oeh == 4'h0 && !(sel && ld && !I_WRITE_SELECT_N) |=> !O_DATA_LANES_OE_N)
    else $error("read data not driven");
  a_tdo_on_fall: assert property ($changed(O_TEST_DATA_OUT) |-> |(tch[7:1] & ~tch[6:0]))
    else $error("test out changed without fall");
  c_read: cover property (en && sel && ld && I_WRITE_SELECT_N);
  c_write: cover property (en && sel && ld && !I_WRITE_SELECT_N);
  c_full: cover property (!O_WBUF_READY);
endmodule : pssp_port_chk

bind pssp_port pssp_port_chk pssp_port_chk_inst (.I_REF_CLK, .I_RST_N, .I_CLOCK_HOLD_N,
  .I_SELECT_LOW_FIRST_N, .I_SELECT_HIGH_SECOND, .I_SELECT_LOW_THIRD_N, .I_ADVANCE_OR_LOAD_N,
  .I_WRITE_SELECT_N, .I_OUTPUT_ENABLE_N, .O_DATA_LANES, .O_DATA_LANES_OE_N, .O_PARITY_LANES,
  .O_PARITY_LANES_OE_N, .I_TEST_CLK, .O_TEST_DATA_OUT, .O_WBUF_READY);
`default_nettype wire

// File: sim/test_pssp_port.sv
// self-checking bench for the sram port
`timescale 1ns/1ps
`default_nettype none
module test_pssp_port;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        oe_n = 1'b0;
  logic        mode = 1'b1;
  logic        tck = 1'b0;
  logic        tdi = 1'b1;
  logic        hold_n, adv_n, we_n, oe_d, oe_p, tdo, rdy;
  logic [2:0]  sel;
  logic [3:0]  bw;
  logic [5:0]  addr;
  logic [35:0] d, q;
  int          n_errors = 0;
  int          compares = 0;
  always #2.5 clk = ~clk;
  pssp_port pssp_port_inst (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_CLOCK_HOLD_N(hold_n),
    .I_SELECT_LOW_FIRST_N(sel[2]), .I_SELECT_HIGH_SECOND(sel[1]), .I_SELECT_LOW_THIRD_N(sel[0]),
    .I_ADVANCE_OR_LOAD_N(adv_n), .I_WRITE_SELECT_N(we_n), .I_LANE_WRITE_SELECT_N(bw),
    .I_ADDR(addr), .I_OUTPUT_ENABLE_N(oe_n), .I_DATA_LANES(d[31:0]), .O_DATA_LANES(q[31:0]),
    .O_DATA_LANES_OE_N(oe_d), .I_PARITY_LANES(d[35:32]), .O_PARITY_LANES(q[35:32]),
    .O_PARITY_LANES_OE_N(oe_p), .I_BURST_ORDER(mode), .I_TEST_CLK(tck), .I_TEST_DATA_IN(tdi),
    .O_TEST_DATA_OUT(tdo), .O_WBUF_READY(rdy));
  pssp_host host_inst (.i_clk(clk), .i_rdy(rdy), .i_oe_n(oe_d), .i_q(q), .o_hold_n(hold_n),
    .o_sel(sel), .o_adv_n(adv_n), .o_we_n(we_n), .o_bw_n(bw), .o_addr(addr), .o_d(d));
  function automatic logic [35:0] pat(input logic [5:0] a);
    return {a[3:0], 26'h2b0f00, a};
  endfunction : pat
  task automatic cmp(input string nm, input logic [35:0] e, input logic [35:0] s);
    compares++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
      n_errors++;
    end
  endtask : cmp
  task automatic conclude;
    n_errors += host_inst.hung;
    $display("compares %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  task automatic reset_dut(input logic m);
    rst_n <= 1'b0;
    // strap moves only while in reset
    mode <= m;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask : reset_dut
  // deselect first so the enable has settled before the read
  task automatic rd(input logic [5:0] a, input logic o, input logic [35:0] e);
    oe_n <= o;
    host_inst.op(1'b0, 1'b0, 4'hf, 6'h0, 36'h0);
    repeat (3) @(posedge clk);
    host_inst.op(1'b1, 1'b0, 4'hf, a, 36'h0);
    host_inst.op(1'b0, 1'b0, 4'hf, 6'h0, 36'h0);
    #1;
    cmp("lanes_oe_n", 36'(o), 36'(oe_d));
    if (!o) cmp("read_data", e, q);
    @(posedge clk);
  endtask : rd
  task automatic t_write_read;
    logic [35:0] m;
    m = {4'ha, 32'hff00ff00};
    host_inst.op(1'b1, 1'b1, 4'h0, 6'h05, pat(6'h05));
    host_inst.op(1'b1, 1'b1, 4'h0, 6'h06, pat(6'h06));
    host_inst.op(1'b1, 1'b1, 4'h5, 6'h06, ~pat(6'h06));
    rd(6'h06, 1'b1, 36'h0);
    rd(6'h06, 1'b0, (~pat(6'h06) & m) | (pat(6'h06) & ~m));
    rd(6'h05, 1'b0, pat(6'h05));
    $display("test write_read done");
  endtask : t_write_read
  task automatic t_hold;
    host_inst.op(1'b1, 1'b0, 4'hf, 6'h05, 36'h0);
    host_inst.o_hold_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    cmp("held_oe_n", 36'h1, 36'(oe_d));
    @(posedge clk);
    host_inst.o_hold_n <= 1'b0;
    host_inst.op(1'b0, 1'b0, 4'hf, 6'h0, 36'h0);
    #1;
    cmp("resumed_data", pat(6'h05), q);
    @(posedge clk);
    $display("test hold done");
  endtask : t_hold
  // one wrong select level at a time must leave the read untaken
  task automatic t_select;
    logic [2:0] p [3];
    p = '{3'b110, 3'b000, 3'b011};
    oe_n <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      host_inst.desel = p[i];
      host_inst.op(1'b0, 1'b0, 4'hf, 6'h05, 36'h0);
      host_inst.desel = 3'b101;
      host_inst.op(1'b0, 1'b0, 4'hf, 6'h0, 36'h0);
      #1;
      cmp("partial_select_oe_n", 36'h1, 36'(oe_d));
      @(posedge clk);
    end
    $display("test select done");
  endtask : t_select
  task automatic t_tap;
    for (int i = 0; i < 2; i++) begin
      tck <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
      cmp("tdo_after_rise", 36'(i), 36'(tdo));
      @(posedge clk);
      tck <= 1'b0;
      tdi <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      cmp("tdo_after_fall", 36'(i == 0), 36'(tdo));
      @(posedge clk);
    end
    $display("test tap done");
  endtask : t_tap
  task automatic t_burst(input logic m);
    int a;
    reset_dut(m);
    for (int k = 8; k < 12; k++) host_inst.op(1'b1, 1'b1, 4'h0, 6'(k), pat(6'(k)));
    host_inst.op(1'b0, 1'b0, 4'hf, 6'h0, 36'h0);
    repeat (8) @(posedge clk);
    host_inst.op(1'b1, 1'b0, 4'hf, 6'h09, 36'h0);
    host_inst.o_adv_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      #1;
      a = m ? (1 ^ i) : ((1 + i) % 4);
      cmp("burst_data", pat(6'(8 + a)), q);
    end
    @(posedge clk);
    host_inst.op(1'b0, 1'b0, 4'hf, 6'h0, 36'h0);
    $display("test burst done");
  endtask : t_burst
  initial begin
    reset_dut(1'b1);
    t_write_read();
    t_hold();
    t_select();
    t_tap();
    t_burst(1'b1);
    t_burst(1'b0);
    conclude();
  end
endmodule : test_pssp_port
`default_nettype wire
